// ---- core/i2c_gc_pkg.sv ----
// Purpose: shared constants for the i2c general call slave
// Assumes: 32-bit ahb-lite register bus, one word per register
// Notes: status bits 0..6 are sticky, mask uses the same layout
package i2c_gc_pkg;
    localparam logic [7:0] ctrl_off = 8'h00;
    localparam logic [7:0] stat_off = 8'h04;
    localparam logic [7:0] mask_off = 8'h08;
    localparam logic [7:0] data_off = 8'h0c;
    localparam logic [7:0] own_off = 8'h10;
    localparam logic [7:0] gcode_off = 8'h14;

    localparam int ctrl_unit_en = 0;
    localparam int ctrl_xfer = 1;
    localparam int ctrl_ack_nack = 2;
    localparam int ctrl_gc_dis = 3;
    localparam int ctrl_w = 4;

    localparam int st_sad = 0;
    localparam int st_gcd = 1;
    localparam int st_rxf = 2;
    localparam int st_txe = 3;
    localparam int st_stop = 4;
    localparam int st_gc_rst = 5;
    localparam int st_gc_store = 6;
    localparam int st_w = 7;
    localparam int st_busy = 8;
    localparam int st_rw = 9;
    localparam int st_rx_nack = 10;

    localparam logic [6:0] gc_addr = 7'h00;
    localparam logic [7:0] gc_code_reset = 8'h06;
    localparam logic [7:0] gc_code_store = 8'h04;
    localparam logic [7:0] gc_code_bad = 8'h00;

    localparam logic [ctrl_w-1:0] ctrl_rst = 4'h0;
    localparam logic [6:0] own_rst = 7'h00;
    localparam logic [3:0] bits_per_byte = 4'h8;
    localparam logic [1:0] htrans_nonseq = 2'h2;
endpackage

// ---- core/i2c_line_if.sv ----
// Purpose: synchronised bus line levels and events between modules
// Assumes: all signals on hclk
// Notes: events are one-cycle pulses
interface i2c_line_if;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start;
    logic stop;
    modport src (output scl, sda, scl_rise, scl_fall, start, stop);
    modport dst (input scl, sda, scl_rise, scl_fall, start, stop);
endinterface

// ---- core/i2c_line_sync.sv ----
// Purpose: brings scl and sda into hclk and finds their edges
// Assumes: line levels change far slower than hclk
// Notes: first flop of each pair feeds only the second
module i2c_line_sync (
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic scl_in,
    input wire logic sda_in,
    i2c_line_if.src line
);
    logic scl_m;
    logic scl_s;
    logic scl_d;
    logic sda_m;
    logic sda_s;
    logic sda_d;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_m <= scl_in;
            scl_s <= scl_m;
            scl_d <= scl_s;
            sda_m <= sda_in;
            sda_s <= sda_m;
            sda_d <= sda_s;
        end
    end

    assign line.scl = scl_s;
    assign line.sda = sda_s;
    assign line.scl_rise = scl_s & ~scl_d;
    assign line.scl_fall = ~scl_s & scl_d;
    // start and stop are sda edges while scl stays high
    assign line.start = scl_s & scl_d & sda_d & ~sda_s;
    assign line.stop = scl_s & scl_d & ~sda_d & sda_s;
endmodule

// ---- core/i2c_general_call_slave.sv ----
// Purpose: i2c slave with general call handling behind an ahb-lite register file
// Assumes: hclk far faster than scl; scl and sda sampled through two flops
// Notes: the slave stretches scl low between bytes until the transfer bit is set
module i2c_general_call_slave
    import i2c_gc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    output logic irq,
    input wire logic scl_in,
    output logic scl_out,
    output logic scl_oe,
    input wire logic sda_in,
    output logic sda_out,
    output logic sda_oe
);
    typedef enum logic [2:0] {
        s_idle, s_addr, s_addr_ack, s_hold, s_rx, s_rx_ack, s_tx, s_tx_ack
    } slave_state_e;

    i2c_line_if line ();

    i2c_line_sync u_sync (
        .hclk(hclk),
        .hresetn(hresetn),
        .scl_in(scl_in),
        .sda_in(sda_in),
        .line(line)
    );

    slave_state_e state;
    logic [ctrl_w-1:0] bus_control_reg;
    logic [st_w-1:0] bus_status_reg;
    logic [st_w-1:0] irq_mask_reg;
    logic [7:0] data_buffer_reg;
    logic [6:0] own_slave_address_reg;
    logic [7:0] gc_code_reg;
    logic [7:0] shifter;
    logic [3:0] bit_cnt;
    logic rw_bit;
    logic rx_nack;
    logic gc_active;
    logic gc_second;
    logic ignoring;
    logic [st_w-1:0] st_set;
    logic xfer_taken;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic rd_req;
    logic wr_req;
    logic [31:0] next_rdata;

    function automatic logic is_gc(input logic [7:0] a);
        return a[7:1] == gc_addr;
    endfunction

    function automatic logic [31:0] reg_word(input logic [st_w-1:0] v);
        return {{(32 - st_w){1'b0}}, v};
    endfunction

    // ---------------- ahb-lite slave ----------------
    assign rd_req = hsel & hready & (htrans == htrans_nonseq) & ~hwrite;
    assign wr_req = hsel & hready & (htrans == htrans_nonseq) & hwrite;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend <= 1'b0;
            wr_addr <= 8'h00;
        end else begin
            wr_pend <= wr_req;
            wr_addr <= haddr;
        end
    end

    always_comb begin
        next_rdata = 32'h0000_0000;
        case (haddr)
            ctrl_off: next_rdata = {28'h000_0000, bus_control_reg};
            stat_off: next_rdata = reg_word(bus_status_reg)
                | ({31'h0000_0000, state != s_idle} << st_busy)
                | ({31'h0000_0000, rw_bit} << st_rw)
                | ({31'h0000_0000, rx_nack} << st_rx_nack);
            mask_off: next_rdata = reg_word(irq_mask_reg);
            data_off: next_rdata = {24'h00_0000, data_buffer_reg};
            own_off: next_rdata = {25'h000_0000, own_slave_address_reg};
            gcode_off: next_rdata = {24'h00_0000, gc_code_reg};
            default: next_rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hrdata <= rd_req ? next_rdata : 32'h0000_0000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end
    end

    // control: the transfer bit is set by software and cleared when used
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_control_reg <= ctrl_rst;
        end else if (wr_pend && wr_addr == ctrl_off) begin
            bus_control_reg <= hwdata[ctrl_w-1:0];
        end else if (xfer_taken) begin
            bus_control_reg[ctrl_xfer] <= 1'b0;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_mask_reg <= '0;
            own_slave_address_reg <= own_rst;
        end else if (wr_pend) begin
            if (wr_addr == mask_off) begin
                irq_mask_reg <= hwdata[st_w-1:0];
            end
            if (wr_addr == own_off) begin
                own_slave_address_reg <= hwdata[6:0];
            end
        end
    end

    // sticky status: a set in the same cycle as a write-one clear wins
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            bus_status_reg <= '0;
        end else if (wr_pend && wr_addr == stat_off) begin
            bus_status_reg <= (bus_status_reg & ~hwdata[st_w-1:0]) | st_set;
        end else begin
            bus_status_reg <= bus_status_reg | st_set;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq <= 1'b0;
        end else begin
            irq <= |(bus_status_reg & irq_mask_reg);
        end
    end

    // data buffer: written by software, loaded by received bytes
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            data_buffer_reg <= 8'h00;
        end else if (state == s_rx && line.scl_fall && bit_cnt == bits_per_byte) begin
            data_buffer_reg <= shifter;
        end else if (wr_pend && wr_addr == data_off) begin
            data_buffer_reg <= hwdata[7:0];
        end
    end

    // ---------------- bus side ----------------
    assign xfer_taken = (state == s_hold) && bus_control_reg[ctrl_xfer];

    always_comb begin
        st_set = '0;
        if (state == s_addr && line.scl_fall && bit_cnt == bits_per_byte) begin
            if (is_gc(shifter)) begin
                if (!bus_control_reg[ctrl_gc_dis] && !shifter[0]) begin
                    st_set[st_sad] = 1'b1;
                    st_set[st_gcd] = 1'b1;
                end
            end else if (shifter[7:1] == own_slave_address_reg) begin
                st_set[st_sad] = 1'b1;
            end
        end
        if (state == s_rx && line.scl_fall && bit_cnt == bits_per_byte) begin
            st_set[st_rxf] = 1'b1;
            if (gc_second && shifter == gc_code_reset) begin
                st_set[st_gc_rst] = 1'b1;
            end
            if (gc_second && shifter == gc_code_store) begin
                st_set[st_gc_store] = 1'b1;
            end
        end
        if (state == s_tx_ack && line.scl_fall && !rx_nack) begin
            st_set[st_txe] = 1'b1;
        end
        if (state != s_idle && line.stop) begin
            st_set[st_stop] = 1'b1;
        end
    end

    // serial state machine
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state <= s_idle;
            shifter <= 8'h00;
            bit_cnt <= 4'h0;
            rw_bit <= 1'b0;
            rx_nack <= 1'b0;
            gc_active <= 1'b0;
            gc_second <= 1'b0;
            ignoring <= 1'b0;
            gc_code_reg <= 8'h00;
        end else if (!bus_control_reg[ctrl_unit_en] || line.stop) begin
            state <= s_idle;
            bit_cnt <= 4'h0;
            gc_active <= 1'b0;
            gc_second <= 1'b0;
            ignoring <= 1'b0;
        end else if (line.start) begin
            state <= s_addr;
            bit_cnt <= 4'h0;
            gc_active <= 1'b0;
            gc_second <= 1'b0;
            ignoring <= 1'b0;
        end else begin
            case (state)
                s_idle: begin
                    bit_cnt <= 4'h0;
                end
                s_addr: begin
                    if (line.scl_rise && bit_cnt != bits_per_byte) begin
                        shifter <= {shifter[6:0], line.sda};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (line.scl_fall && bit_cnt == bits_per_byte) begin
                        bit_cnt <= 4'h0;
                        rw_bit <= shifter[0];
                        if (is_gc(shifter)) begin
                            // accept software general call write only
                            if (!bus_control_reg[ctrl_gc_dis] && !shifter[0]) begin
                                state <= s_addr_ack;
                                gc_active <= 1'b1;
                                gc_second <= 1'b1;
                            end else begin
                                state <= s_idle;
                            end
                        end else if (shifter[7:1] == own_slave_address_reg) begin
                            state <= s_addr_ack;
                        end else begin
                            state <= s_idle;
                        end
                    end
                end
                s_addr_ack: begin
                    if (line.scl_fall) begin
                        state <= s_hold;
                    end
                end
                s_hold: begin
                    if (bus_control_reg[ctrl_xfer]) begin
                        if (ignoring) begin
                            state <= s_idle;
                        end else if (rw_bit) begin
                            state <= s_tx;
                            shifter <= data_buffer_reg;
                        end else begin
                            state <= s_rx;
                        end
                        bit_cnt <= 4'h0;
                    end
                end
                s_rx: begin
                    if (line.scl_rise && bit_cnt != bits_per_byte) begin
                        shifter <= {shifter[6:0], line.sda};
                        bit_cnt <= bit_cnt + 4'h1;
                    end else if (line.scl_fall && bit_cnt == bits_per_byte) begin
                        state <= s_rx_ack;
                        gc_second <= 1'b0;
                        if (gc_second) begin
                            gc_code_reg <= shifter;
                        end
                        // lsb set or forbidden code: drop out
                        if (gc_second && (shifter[0] || shifter == gc_code_bad)) begin
                            ignoring <= 1'b1;
                        end
                    end
                end
                s_rx_ack: begin
                    if (line.scl_fall) begin
                        state <= s_hold;
                    end
                end
                s_tx: begin
                    if (line.scl_fall) begin
                        shifter <= {shifter[6:0], 1'b0};
                        bit_cnt <= bit_cnt + 4'h1;
                        if (bit_cnt == bits_per_byte - 4'h1) begin
                            state <= s_tx_ack;
                        end
                    end
                end
                s_tx_ack: begin
                    if (line.scl_rise) begin
                        rx_nack <= line.sda;
                    end else if (line.scl_fall) begin
                        state <= rx_nack ? s_idle : s_hold;
                    end
                end
                default: begin
                    state <= s_idle;
                end
            endcase
        end
    end

    // pin drivers, open drain: the output level is always low
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sda_oe <= 1'b0;
            scl_oe <= 1'b0;
            sda_out <= 1'b0;
            scl_out <= 1'b0;
        end else begin
            sda_out <= 1'b0;
            scl_out <= 1'b0;
            // stretch scl while software has not set the transfer bit
            scl_oe <= (state == s_hold) && !bus_control_reg[ctrl_xfer]
                && !line.scl;
            case (state)
                s_addr_ack: sda_oe <= 1'b1;
                // ack per ack/nack bit, never on dropped bytes
                s_rx_ack: sda_oe <= !bus_control_reg[ctrl_ack_nack] && !ignoring;
                s_tx: sda_oe <= !shifter[7];
                s_tx_ack: sda_oe <= 1'b0;
                default: sda_oe <= 1'b0;
            endcase
        end
    end
endmodule

// ---- tb/i2c_gc_monitor.sv ----
// Purpose: port-level checks for the general call slave
// Assumes: one hclk domain, zero wait state bus
// Notes: bus phases and the enable bit are shadowed from bus traffic
module i2c_gc_monitor
    import i2c_gc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [7:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic hready,
    input wire logic [31:0] hwdata,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    input wire logic irq,
    input wire logic scl_in,
    input wire logic scl_out,
    input wire logic scl_oe,
    input wire logic sda_out,
    input wire logic sda_oe
);
    timeunit 1ns;
    timeprecision 100ps;
    logic rd_q;
    logic wr_q;
    logic en_q;
    logic [7:0] addr_q;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rd_q <= 1'b0;
            wr_q <= 1'b0;
            addr_q <= 8'h00;
        end else begin
            rd_q <= hsel && hready && htrans == htrans_nonseq && !hwrite;
            wr_q <= hsel && hready && htrans == htrans_nonseq && hwrite;
            addr_q <= haddr;
        end
    end

    // enable bit as software last wrote it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            en_q <= 1'b0;
        end else if (wr_q && addr_q == ctrl_off) begin
            en_q <= hwdata[ctrl_unit_en];
        end
    end

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    resp_okay_a: assert property (hresp == 1'b0)
        else $error("response not okay");
    ready_high_a: assert property (hreadyout == 1'b1)
        else $error("wait state inserted");
    rdata_idle_a: assert property (!rd_q |-> hrdata == 32'h0)
        else $error("read data outside data phase");
    rdata_upper_a: assert property (rd_q |-> hrdata[31:11] == 21'h0)
        else $error("upper read bits set");
    unmapped_zero_a: assert property (rd_q && addr_q > gcode_off |-> hrdata == 32'h0)
        else $error("unmapped read not zero");
    open_drain_a: assert property (scl_out == 1'b0 && sda_out == 1'b0)
        else $error("line driven high");
    sda_change_a: assert property ($changed(sda_oe) |-> !scl_in)
        else $error("sda changed while scl high");
    stretch_low_a: assert property ($rose(scl_oe) |-> !scl_in)
        else $error("stretch began with scl high");
    mask_irq_a: assert property (
        wr_q && addr_q == mask_off && hwdata[6:0] == 7'h0 |-> ##2 !irq)
        else $error("irq high with all masked");
    disabled_idle_a: assert property (
        !en_q && !$past(en_q) && !$past(en_q, 2) |-> !sda_oe && !scl_oe)
        else $error("disabled unit drives lines");
endmodule

bind i2c_general_call_slave i2c_gc_monitor mon (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hready(hready), .hwdata(hwdata),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq),
    .scl_in(scl_in), .scl_out(scl_out), .scl_oe(scl_oe),
    .sda_out(sda_out), .sda_oe(sda_oe)
);

// ---- tb/i2c_bus_master_model.sv ----
// Purpose: behavioural bus master on the open-drain wires
// Assumes: pull-ups on both wires, bit time 320 ns
// Notes: waits for a stretched scl under a bound
module i2c_bus_master_model (
    input wire logic scl,
    input wire logic sda,
    output logic scl_low,
    output logic sda_low
);
    timeunit 1ns;
    timeprecision 100ps;

    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    task automatic rel_scl();
        int n;
        n = 0;
        scl_low = 1'b0;
        while (scl !== 1'b1 && n < 400) begin
            #40;
            n++;
        end
    endtask

    // one bit: drive b, sample the wire mid-high
    // scl low 200 ns so the slave's synced sda change lands before scl rises
    task automatic bit_io(input logic b, output logic s);
        sda_low = !b;
        #160;
        rel_scl();
        #60;
        s = sda;
        #60;
        scl_low = 1'b1;
        #40;
    endtask

    task automatic start();
        sda_low = 1'b1;
        #160;
        scl_low = 1'b1;
        #40;
    endtask

    task automatic stop();
        sda_low = 1'b1;
        #120;
        rel_scl();
        #160;
        sda_low = 1'b0;
        #160;
    endtask

    task automatic wr_byte(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], s);
        end
        bit_io(1'b1, ack);
    endtask

    task automatic rd_byte(input logic nack, output logic [7:0] d, output logic s);
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, d[i]);
        end
        bit_io(nack, s);
    endtask
endmodule

// ---- tb/tb.sv ----
// Purpose: bus and wire scenarios for the general call slave
// Assumes: zero wait state bus, master model on the wires
// Notes: wire levels are resolved here from all enables
module tb
    import i2c_gc_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, irq;
    logic scl_out, scl_oe, sda_out, sda_oe, m_scl_low, m_sda_low, ack, s;
    logic [7:0] haddr, d;
    logic [1:0] htrans;
    logic [31:0] hwdata, hrdata, rd;
    logic [7:0] offs [6] = '{ctrl_off, stat_off, mask_off, data_off, own_off, gcode_off};
    logic [7:0] codes [4] = '{8'h06, 8'h04, 8'h00, 8'h07};
    logic [3:0] acks = 4'b1100;
    logic [7:0] flags [4] = '{8'h20, 8'h40, 8'h00, 8'h00};
    int num_errors, num_checks, cycles;
    wire scl_w = !((scl_oe && !scl_out) || m_scl_low);
    wire sda_w = !((sda_oe && !sda_out) || m_sda_low);

    i2c_general_call_slave uut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hready(hreadyout),
        .hwdata(hwdata), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .irq(irq), .scl_in(scl_w), .scl_out(scl_out), .scl_oe(scl_oe),
        .sda_in(sda_w), .sda_out(sda_out), .sda_oe(sda_oe)
    );
    i2c_bus_master_model m (.scl(scl_w), .sda(sda_w), .scl_low(m_scl_low), .sda_low(m_sda_low));

    always #20 hclk = !hclk;

    task automatic results();
        $display("errors=%0d checks=%0d", num_errors, num_checks);
        if (num_errors == 0 && num_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            num_errors++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        int n;
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= htrans_nonseq;
        haddr <= a;
        hwrite <= w;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        n = 0;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 50);
        rd = hrdata;
    endtask

    task automatic rchk(input logic [7:0] a, input logic [31:0] msk, input logic [31:0] exp);
        bus(1'b0, a, 32'h0);
        chk(rd & msk, exp);
    endtask

    // releases a stretched scl by writing the control value with xfer set
    task automatic go(input logic [3:0] c);
        int n;
        n = 0;
        while (scl_oe !== 1'b1 && n < 10) begin
            @(posedge hclk);
            n++;
        end
        if (scl_oe === 1'b1) begin
            bus(1'b1, ctrl_off, {28'h0, c | 4'h2});
        end else begin
            num_errors++;
        end
    endtask

    task automatic irqchk(input logic exp);
        repeat (2) @(posedge hclk);
        chk(32'(irq), 32'(exp));
    endtask

    initial begin
        hclk = 1'b0;
        hresetn = 1'b0;
        hsel = 1'b0;
        hwrite = 1'b0;
        haddr = 8'h00;
        htrans = 2'h0;
        hwdata = 32'h0;
        cycles = 0;
        repeat (3) @(posedge hclk);
        hresetn <= 1'b1;
        foreach (offs[i]) rchk(offs[i], 32'hffffffff, 32'h0);
        bus(1'b1, 8'h20, 32'hffffffff);
        rchk(8'h20, 32'hffffffff, 32'h0);
        bus(1'b1, own_off, 32'h2a);
        bus(1'b1, mask_off, 32'h7f);
        bus(1'b1, ctrl_off, 32'h9);
        m.start();
        m.wr_byte({gc_addr, 1'b0}, ack);
        chk(32'(ack), 32'h1);
        m.stop();
        rchk(stat_off, 32'h63, 32'h0);
        bus(1'b1, stat_off, 32'h7f);
        bus(1'b1, ctrl_off, 32'h1);
        for (int i = 0; i < 4; i++) begin
            m.start();
            m.wr_byte({gc_addr, 1'b0}, ack);
            chk(32'(ack), 32'h0);
            rchk(stat_off, 32'h3, 32'h3);
            chk(32'(irq), 32'h1);
            bus(1'b1, stat_off, 32'h7f);
            go(4'h1);
            m.wr_byte(codes[i], ack);
            chk(32'(ack), 32'(acks[i]));
            go(4'h1);
            m.stop();
            rchk(stat_off, 32'h60, 32'(flags[i]));
            if (!acks[i]) rchk(gcode_off, 32'hff, 32'(codes[i]));
            bus(1'b1, stat_off, 32'h7f);
        end
        rchk(own_off, 32'h7f, 32'h2a);
        m.start();
        m.wr_byte(8'h55, ack);
        chk(32'(ack), 32'h0);
        rchk(stat_off, 32'h301, 32'h301);
        bus(1'b1, data_off, 32'ha5);
        go(4'h1);
        m.rd_byte(1'b1, d, s);
        chk(32'(d), 32'ha5);
        chk(32'(s), 32'h1);
        rchk(stat_off, 32'h400, 32'h400);
        m.stop();
        bus(1'b1, stat_off, 32'h7f);
        m.start();
        m.wr_byte(8'h54, ack);
        chk(32'(ack), 32'h0);
        go(4'h5);
        m.wr_byte(8'h3c, ack);
        chk(32'(ack), 32'h1);
        rchk(data_off, 32'hff, 32'h3c);
        rchk(stat_off, 32'h4, 32'h4);
        go(4'h1);
        m.stop();
        bus(1'b1, mask_off, 32'h0);
        irqchk(1'b0);
        bus(1'b1, mask_off, 32'h4);
        irqchk(1'b1);
        bus(1'b1, stat_off, 32'h7f);
        irqchk(1'b0);
        results();
    end
endmodule
